// file: rtl/ppm_pkg.sv
/*
 Package for the panel pixel output mapper: field positions, widths,
 reset values and states shared by the mapper and its buffer.
 Assumes a single 50 MHz core clock and no software-visible registers.
*/
// Behaviour
// - One-pixel 24-bit: blue, green, red bytes ascending
// - Reduced depth colours justified to top bits
// - Two-pixel: first pixel even bus, second odd
// - Odd bus uses same colour field layout
// - 18-bit uses six bits per colour only
// - Colour only when active, syncs only blanking
// - Lane zero blue, one green, two red
// - Output pixel mode independent of transmitter input
// - Link delivers one pixel per link clock
// - Output clock shifts panel, syncs forwarded alongside
package ppm_pkg;
   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int PPM_LANE_W = 8;          // Bits per colour lane
   localparam int PPM_DEEP_W = 6;          // Bits per colour at 18 bpp
   localparam int PPM_BUS_W = 24;          // Pixel bus width
   localparam int PPM_BLUE_LSB = 0;        // Blue field position
   localparam int PPM_GREEN_LSB = 8;       // Green field position
   localparam int PPM_RED_LSB = 16;        // Red field position
   localparam int PPM_SYNC_STAGES = 3;     // Pin synchroniser depth
   localparam logic [23:0] PPM_BUS_RST = 24'h000000; // Bus after reset
   // Word stored in buffer: vsync, hsync, de, pixel
   localparam int PPM_WORD_W = 27;
   localparam int PPM_DE_BIT = 24;
   localparam int PPM_HS_BIT = 25;
   localparam int PPM_VS_BIT = 26;
   // Pairing state for two-pixel mode (Gray order)
   typedef enum logic [1:0] {
      PPM_WAIT_FIRST = 2'b00,
      PPM_WAIT_SECOND = 2'b01
   } ppm_pair_t;
endpackage : ppm_pkg

// file: rtl/ppm_buffer.sv
/*
 Two-entry valid/ready buffer for mapped pixel words.
 Assumes one clock domain, synchronous active-low reset and a clock enable.
*/
`timescale 1ns/10ps
module ppm_buffer
   import ppm_pkg::*;
#(
   parameter int WIDTH = PPM_WORD_W,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Elaboration check: the pointers and count below serve two entries only
   if (DEPTH != 2 || WIDTH < 1) begin : g_bad_param
      $error("ppm_buffer serves DEPTH 2 and WIDTH of at least 1 only");
   end
   logic [WIDTH-1:0] mem [DEPTH];  // Entries
   logic wr_ptr;                   // Write slot
   logic rd_ptr;                   // Read slot
   logic [1:0] count;              // Occupancy
   wire push = in_valid_i && (count != 2'd2);
   wire pop = out_ready_i && (count != 2'd0);
   assign in_ready_o = (count != 2'd2);
   assign out_valid_o = (count != 2'd0);
   assign out_data_o = mem[rd_ptr];
   // Pointer and occupancy update
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'd0;
      end else if (ce_i) begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop) rd_ptr <= ~rd_ptr;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
   // Data store
   always_ff @(posedge clk_i) begin
      if (ce_i && push) mem[wr_ptr] <= in_data_i;
   end
endmodule : ppm_buffer

// file: rtl/ppm_mapper.sv
/*
 Panel pixel output mapper: samples decoded lanes on the link clock edge,
 maps them onto even and odd 24-bit pixel buses, pairs pixels in
 two-pixel mode, and drives panel shift clock, syncs and enable.
 Assumes link inputs come from another clock domain and are sampled by clk_i.
*/
`timescale 1ns/10ps
module ppm_mapper
   import ppm_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic link_clk_i,             // Link pixel clock
   input wire logic [7:0] lane_zero_blue_i,
   input wire logic [7:0] lane_one_green_i,
   input wire logic [7:0] lane_two_red_i,
   input wire logic display_enable_i,
   input wire logic hsync_i,
   input wire logic vsync_i,
   input wire logic two_pixel_mode_i,       // Static: 1 = two per clock
   input wire logic depth_18_i,             // Static: 1 = 18 bpp
   input wire logic panel_ready_i,          // Panel side accepts a word
   output logic [23:0] even_pixel_bus_o,
   output logic [23:0] odd_pixel_bus_o,
   output logic output_data_clock_o,
   output logic display_enable_o,
   output logic hsync_o,
   output logic vsync_o,
   output logic overrun_o                   // Pixel lost: buffer full
);
   // ----------------------------------------------------------------
   // Pin synchronisers and link clock edge detect
   // ----------------------------------------------------------------
   localparam int PIN_W = 28;               // Link clock, three controls, three lanes
   // The filter below reads stages two and three, so it needs all three
   if (PPM_SYNC_STAGES != 3) begin : g_bad_sync
      $error("ppm_mapper needs exactly three synchroniser stages");
   end
   // Every link-side pin gathered into one vector for the synchronisers
   wire [PIN_W-1:0] pin_raw = {link_clk_i, vsync_i, hsync_i, display_enable_i,
                               lane_two_red_i, lane_one_green_i, lane_zero_blue_i};
   wire [PIN_W-1:0] pin_filt;               // Accepted pin levels
   // Per pin: three samplers; a new level counts once stages two and three agree
   for (genvar gi = 0; gi < PIN_W; gi++) begin : g_pin_sync
      logic [PPM_SYNC_STAGES-1:0] stage;    // Sampler chain, stage one at bit 0
      logic level;                          // Accepted level of this pin
      always_ff @(posedge clk_i) begin
         if (!resetn_i) begin
            stage <= '0;
            level <= 1'b0;
         end else if (ce_i) begin
            stage <= {stage[PPM_SYNC_STAGES-2:0], pin_raw[gi]};
            // Stages two and three disagree while the pin is moving
            if (stage[1] == stage[2]) level <= stage[2];
         end
      end
      assign pin_filt[gi] = level;
   end
   // Named fields of the accepted pins
   wire link_clk_f = pin_filt[27];          // Link clock
   wire vs_f = pin_filt[26];                // Vertical sync
   wire hs_f = pin_filt[25];                // Horizontal sync
   wire de_f = pin_filt[24];                // Display enable
   wire [7:0] red_f = pin_filt[23:16];      // Lane two
   wire [7:0] green_f = pin_filt[15:8];     // Lane one
   wire [7:0] blue_f = pin_filt[7:0];       // Lane zero
   logic link_prev;                         // Accepted link clock, one cycle old
   logic lane_cap;                          // Link edge seen, sample lanes
   // Previous link level; resets low like the idle link, so no false edge
   always_ff @(posedge clk_i) begin
      if (!resetn_i) link_prev <= 1'b0;
      else if (ce_i) link_prev <= link_clk_f;
   end
   // One pixel per rising link clock, whatever the sender's input
   wire link_rise = link_clk_f && !link_prev;
   assign lane_cap = link_rise;
   // Lanes settle long before the link edge is accepted; take them on it
   logic [7:0] s_blue, s_green, s_red;
   logic s_de, s_hs, s_vs;
   logic s_valid;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         s_valid <= 1'b0;
         {s_blue, s_green, s_red} <= PPM_BUS_RST;
         {s_de, s_hs, s_vs} <= 3'b000;
      end else if (ce_i) begin
         s_valid <= lane_cap;
         if (lane_cap) begin
            s_blue <= blue_f;
            s_green <= green_f;
            s_red <= red_f;
            s_de <= de_f;
            s_hs <= hs_f;
            s_vs <= vs_f;
         end
      end
   end

   // ----------------------------------------------------------------
   // Colour justification
   // ----------------------------------------------------------------
   // At 18 bpp keep top six bits, force low two to zero
   wire [7:0] depth_mask = depth_18_i ? 8'hfc : 8'hff;
   // Colour carried only while enable high
   wire [7:0] colour_mask = s_de ? depth_mask : 8'h00;
   wire [23:0] pixel_now = {s_red & colour_mask, s_green & colour_mask,
                            s_blue & colour_mask};
   // Syncs only during blanking
   wire sync_h = s_hs && !s_de;
   wire sync_v = s_vs && !s_de;

   // ----------------------------------------------------------------
   // Pixel pairing
   // ----------------------------------------------------------------
   ppm_pair_t pair_state;                   // Pairing position
   logic [23:0] first_pixel;                // Held first pixel of pair
   logic buf_ready;
   // A word leaves the mapper on every pixel (one mode) or second pixel
   wire emit = s_valid && (!two_pixel_mode_i || pair_state == PPM_WAIT_SECOND);
   // Pair resets at blanking so pairs align to the line start
   wire hold_first = s_valid && two_pixel_mode_i && s_de &&
                     pair_state == PPM_WAIT_FIRST;
   // A lone first pixel cut off by blanking leaves as zero colour
   wire [23:0] pair_even = s_de ? first_pixel : PPM_BUS_RST;
   wire [23:0] even_word = two_pixel_mode_i ? pair_even : pixel_now;
   // One-pixel mode leaves odd bus empty
   wire [23:0] odd_word = two_pixel_mode_i ? pixel_now : PPM_BUS_RST;
   wire [PPM_WORD_W-1:0] word_in = {sync_v, sync_h, s_de, even_word};
   wire [PPM_WORD_W-1:0] word_out;
   logic [23:0] odd_hold;                    // Odd half read from buffer top bits
   logic buf_valid;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pair_state <= PPM_WAIT_FIRST;
         first_pixel <= PPM_BUS_RST;
      end else if (ce_i) begin
         case (pair_state)
            PPM_WAIT_FIRST: begin
               // Hold an active first pixel until its partner arrives
               if (hold_first) begin
                  first_pixel <= pixel_now;
                  pair_state <= PPM_WAIT_SECOND;
               end else if (s_valid && !s_de) begin
                  first_pixel <= PPM_BUS_RST;
               end
            end
            PPM_WAIT_SECOND: begin
               // Any pixel closes the pair; blanking drops a lone first pixel
               if (s_valid) begin
                  pair_state <= PPM_WAIT_FIRST;
                  if (!s_de) first_pixel <= PPM_BUS_RST;
               end
            end
            default: begin
               // Unused code: restart pairing
               pair_state <= PPM_WAIT_FIRST;
            end
         endcase
      end
   end
   wire emit_word = emit || (s_valid && two_pixel_mode_i && !s_de);

   // ----------------------------------------------------------------
   // Output buffer: even half and controls in low bits, odd half in the top 24 bits of each entry
   // ----------------------------------------------------------------
   wire [PPM_WORD_W+23:0] full_in = {odd_word, word_in};
   wire [PPM_WORD_W+23:0] full_out;
   logic out_take;
   ppm_buffer #(.WIDTH(PPM_WORD_W + 24), .DEPTH(2)) u_buf (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .in_data_i(full_in),
      .in_valid_i(emit_word),
      .in_ready_o(buf_ready),
      .out_data_o(full_out),
      .out_valid_o(buf_valid),
      .out_ready_i(out_take)
   );
   assign word_out = full_out[PPM_WORD_W-1:0];
   assign odd_hold = full_out[PPM_WORD_W+23:PPM_WORD_W];

   // ----------------------------------------------------------------
   // Panel side: words leave with a shift clock pulse
   // ----------------------------------------------------------------
   // A word leaves only in the low phase so each word gets its own clock pulse
   assign out_take = buf_valid && panel_ready_i && !output_data_clock_o;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         even_pixel_bus_o <= PPM_BUS_RST;
         odd_pixel_bus_o <= PPM_BUS_RST;
         display_enable_o <= 1'b0;
         hsync_o <= 1'b0;
         vsync_o <= 1'b0;
         output_data_clock_o <= 1'b0;
         overrun_o <= 1'b0;
      end else if (ce_i) begin
         // Shift clock rises in the same cycle as new data
         output_data_clock_o <= out_take;
         if (out_take) begin
            even_pixel_bus_o <= word_out[23:0];
            odd_pixel_bus_o <= odd_hold;
            display_enable_o <= word_out[PPM_DE_BIT];
            hsync_o <= word_out[PPM_HS_BIT];
            vsync_o <= word_out[PPM_VS_BIT];
         end
         overrun_o <= emit_word && !buf_ready;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_odd_bus_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !two_pixel_mode_i && $stable(two_pixel_mode_i) && out_take |=>
         odd_pixel_bus_o == 24'h000000)
      else $error("odd bus carries data in one-pixel mode");
   a_low_bits_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
      depth_18_i && $stable(depth_18_i) && out_take |=>
         even_pixel_bus_o[1:0] == 2'b00 && even_pixel_bus_o[9:8] == 2'b00 &&
         even_pixel_bus_o[17:16] == 2'b00)
      else $error("low colour bits driven at 18 bpp");
   a_blank_no_colour: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !display_enable_o |-> even_pixel_bus_o == 24'h000000)
      else $error("colour present during blanking");
   a_sync_in_blank: assert property (@(posedge clk_i) disable iff (!resetn_i)
      display_enable_o |-> !hsync_o && !vsync_o)
      else $error("sync active during display");
   a_clock_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && out_take |=> output_data_clock_o)
      else $error("shift clock missed new word");
   a_blue_lane: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && s_valid && s_de && !depth_18_i |-> pixel_now[7:0] == s_blue)
      else $error("blue not from lane zero");
   a_red_lane: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && s_valid && s_de && !depth_18_i |-> pixel_now[23:16] == s_red)
      else $error("red field misplaced");
   a_one_per_edge: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && lane_cap |=> s_valid)
      else $error("link edge produced no pixel");
   a_shift_one_cycle: assert property (@(posedge clk_i) disable iff (!resetn_i)
      output_data_clock_o |=> !output_data_clock_o)
      else $error("shift clock high for more than one cycle");
   a_odd_low_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
      depth_18_i && $stable(depth_18_i) && out_take |=>
         odd_pixel_bus_o[1:0] == 2'b00 && odd_pixel_bus_o[9:8] == 2'b00 &&
         odd_pixel_bus_o[17:16] == 2'b00)
      else $error("odd low colour bits driven at 18 bpp");
   a_pair_one_word: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ce_i && hold_first |-> !emit_word)
      else $error("first pixel of a pair sent alone");
endmodule : ppm_mapper

// file: verification/ppm_panel_model.sv
/*
 Panel-side model: latches each word shown with the shift clock pulse
 and can stall the mapper. Assumes it runs on the mapper's core clock.
*/
`timescale 1ns/10ps
module ppm_panel_model (
   input wire logic clk_i,
   input wire logic hold_i,                 // Bench asks for a stall
   input wire logic [23:0] even_pixel_bus_i,
   input wire logic [23:0] odd_pixel_bus_i,
   input wire logic shift_clk_i,
   output logic panel_ready_o,
   output logic [23:0] got_even_o,
   output logic [23:0] got_odd_o,
   output logic [7:0] got_count_o           // Words taken so far
);
   logic ready_q = 1'b1;                    // Ready as last driven
   logic [7:0] count_q = 8'h00;             // Words taken so far
   assign panel_ready_o = ready_q;
   assign got_count_o = count_q;
   // Ready moves off the sampling edge, prompt or stalled
   always @(negedge clk_i) begin
      ready_q <= !hold_i;
   end
   // Word taken while the shift clock stands high
   always @(posedge clk_i) begin
      if (shift_clk_i === 1'b1) begin
         got_even_o <= even_pixel_bus_i;
         got_odd_o <= odd_pixel_bus_i;
         count_q <= count_q + 8'h01;
      end
   end
endmodule : ppm_panel_model

// file: verification/ppm_mapper_tb.sv
/*
 Self-checking bench for the pixel mapper. Assumes the panel model and
 a link clock of 160 ns that stands low between pixels.
*/
`timescale 1ns/10ps
module ppm_mapper_tb;
   import ppm_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic [7:0] lb = 8'h00, lg = 8'h00, lr = 8'h00;
   logic de = 1'b0, hs = 1'b0, vs = 1'b0, two = 1'b0, d18 = 1'b0, hold = 1'b0;
   int ovr_count = 0;
   wire logic rdy, output_data_clock, de_o, hs_o, vs_o, ovr;
   wire logic [23:0] even, odd, ge, go;
   wire logic [7:0] got;
   int bad_count = 0;
   int checks_done = 0;
   logic [7:0] n;
   ppm_mapper i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
      .link_clk_i(link_clk_i), .lane_zero_blue_i(lb), .lane_one_green_i(lg),
      .lane_two_red_i(lr), .display_enable_i(de), .hsync_i(hs), .vsync_i(vs),
      .two_pixel_mode_i(two), .depth_18_i(d18), .panel_ready_i(rdy),
      .even_pixel_bus_o(even), .odd_pixel_bus_o(odd), .output_data_clock_o(output_data_clock),
      .display_enable_o(de_o), .hsync_o(hs_o), .vsync_o(vs_o), .overrun_o(ovr));
   ppm_panel_model i_panel (.clk_i(clk_i), .hold_i(hold), .even_pixel_bus_i(even),
      .odd_pixel_bus_i(odd), .shift_clk_i(output_data_clock), .panel_ready_o(rdy),
      .got_even_o(ge), .got_odd_o(go), .got_count_o(got));
   always #10 clk_i = ~clk_i;
   // Count dropped-word pulses
   always @(negedge clk_i) begin
      if (ovr === 1'b1) begin
         ovr_count++;
      end
   end
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Reset with the static modes set, held 16 cycles
   task automatic rst(input logic t, input logic d);
      @(negedge clk_i);
      two = t;
      d18 = d;
      resetn_i = 1'b0;
      repeat (16) @(negedge clk_i);
      resetn_i = 1'b1;
      n = got;
   endtask : rst
   // One link pixel; lanes turn over once the hold has run out
   task automatic pix(input logic [7:0] b, g, r, input logic e, h, v);
      lb = b;
      lg = g;
      lr = r;
      de = e;
      hs = h;
      vs = v;
      link_clk_i = 1'b1;
      repeat (4) @(negedge clk_i);
      link_clk_i = 1'b0;
      lb = ~b;
      lg = ~g;
      lr = ~r;
      repeat (4) @(negedge clk_i);
   endtask : pix
   // Bounded wait for the panel to take one more word
   task automatic wait_word;
      n = n + 8'h01;
      for (int i = 0; i < 60 && got !== n; i++) @(negedge clk_i);
      chk(got, n);
      if (got !== n) close_out();
   endtask : wait_word
   task automatic t_one;
      rst(1'b0, 1'b0);
      pix(8'h11, 8'h22, 8'h33, 1'b1, 1'b0, 1'b0);
      wait_word();
      chk(ge, 24'h332211);
      chk(go, 24'h000000);
      chk(de_o, 1'b1);
      rst(1'b0, 1'b1);
      pix(8'hff, 8'h81, 8'h47, 1'b1, 1'b0, 1'b0);
      wait_word();
      chk(ge, 24'h4480fc);
      pix(8'ha4, 8'hb8, 8'hcc, 1'b1, 1'b0, 1'b0); // Low bits zero
      wait_word();
      chk(ge, 24'hccb8a4);
      $display("t_one done");
   endtask : t_one
   task automatic t_two;
      rst(1'b1, 1'b0);
      pix(8'h01, 8'h02, 8'h03, 1'b1, 1'b0, 1'b0);
      pix(8'ha1, 8'ha2, 8'ha3, 1'b1, 1'b0, 1'b0);
      wait_word();
      chk(ge, 24'h030201);
      chk(go, 24'ha3a2a1);
      rst(1'b1, 1'b1);
      pix(8'hff, 8'hff, 8'hff, 1'b1, 1'b0, 1'b0);
      pix(8'h13, 8'h57, 8'h9b, 1'b1, 1'b0, 1'b0);
      wait_word();
      chk(ge, 24'hfcfcfc);
      chk(go, 24'h985410);
      pix(8'h12, 8'h34, 8'h56, 1'b1, 1'b0, 1'b0); // Lone first pixel, then blanking
      pix(8'h12, 8'h34, 8'h56, 1'b0, 1'b1, 1'b0);
      wait_word();
      chk(ge, 24'h000000);
      chk(go, 24'h000000);
      chk({hs_o, vs_o, de_o}, 3'b100);
      $display("t_two done");
   endtask : t_two
   task automatic t_blank;
      rst(1'b0, 1'b0);
      pix(8'h55, 8'h66, 8'h77, 1'b0, 1'b1, 1'b1);
      wait_word();
      chk(ge, 24'h000000);
      chk({hs_o, vs_o, de_o}, 3'b110);
      pix(8'h55, 8'h66, 8'h77, 1'b1, 1'b1, 1'b1);
      wait_word();
      chk(ge, 24'h776655);
      chk({hs_o, vs_o, de_o}, 3'b001);
      $display("t_blank done");
   endtask : t_blank
   // Panel stalls while pixels keep coming: buffer fills, then drains
   task automatic t_stall;
      int o0;
      hold = 1'b1;
      rst(1'b0, 1'b0);
      o0 = ovr_count;
      for (int i = 1; i < 6; i++) pix(8'(i), 8'(i), 8'(i), 1'b1, 1'b0, 1'b0);
      chk(got, n);
      chk(ovr_count - o0, 3);
      hold = 1'b0;
      wait_word();
      chk(ge, 24'h010101);
      wait_word();
      chk(ge, 24'h020202);
      $display("t_stall done");
   endtask : t_stall
   initial begin
      t_one();
      t_two();
      t_blank();
      t_stall();
      close_out();
   end
endmodule : ppm_mapper_tb
